// >>> hw/decoder_pkg.sv
// Constants shared by the instruction field decoder and its field slices.
package decoder_pkg;
  // Field limits, bit 0 being the most significant bit of the word
  localparam int INSTR_W          = 32;
  localparam int STORE_SRC_FIRST  = 6;
  localparam int STORE_SRC_LAST   = 10;
  localparam int FIRST_OP_FIRST   = 11;
  localparam int FIRST_OP_LAST    = 15;
  localparam int SECOND_SRC_FIRST = 16;
  localparam int SECOND_SRC_LAST  = 20;
  localparam int ROTATE_FIRST     = 16;
  localparam int ROTATE_LAST      = 20;
  localparam int IMM_FIRST        = 16;
  localparam int IMM_LAST         = 31;
  localparam int SPECIAL_FIRST    = 11;
  localparam int SPECIAL_LAST     = 20;
  localparam int TRAP_FIRST       = 6;
  localparam int TRAP_LAST        = 10;
  localparam int OVF_ENABLE_BIT   = 21;
  localparam int RECORD_BIT       = 31;

  // Condition flag positions, bit 0 being the leftmost flag
  localparam int CF_LT   = 0;
  localparam int CF_GT   = 1;
  localparam int CF_ZERO = 2;
  localparam int CF_SO   = 3;
  localparam int CF_FX   = 4;
  localparam int CF_FEX  = 5;
  localparam int CF_VX   = 6;
  localparam int CF_OX   = 7;

  // Values after reset
  localparam logic [7:0]  COND_FLAGS_RST = 8'h00;
  localparam logic        EXC_FLAG_RST   = 1'b0;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;
endpackage

// >>> hw/field_slice.sv
// Registered extraction of one field of the instruction word.
`timescale 1ns/1ns
module field_slice #(
  parameter int FIRST = 0,
  parameter int LAST  = 0,
  parameter int WIDTH = LAST - FIRST + 1
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_load,
  input  wire logic [31:0]        i_word,
  output logic      [WIDTH-1:0]   o_field
);
  generate
    if (FIRST < 0 || LAST > 31 || FIRST > LAST || WIDTH != LAST - FIRST + 1) begin : g_bad
      $error("field_slice: field limits out of range");
    end
  endgenerate

  // Bit n of the word sits at vector index 31-n
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_field <= '0;
    end else if (i_load) begin
      o_field <= i_word[31-FIRST -: WIDTH];
    end
  end
endmodule

// >>> hw/instruction_field_decoder.sv
// Instruction field decoder with record-flag driven condition flag and overflow-enable driven exception flag update.
// Notes on behaviour
// - Store source from bits 6-10, second source from bits 16-20.
// - Result destination register selector comes from bits 6-10.
// - Bit 31 clear keeps condition flags; set updates them from result.
// - Integer record sets flags 0-2 from result as signed value, flag 3 from summary overflow.
// - Float record loads flags 4-7 with FX, FEX, VX, OX summaries.
// - Shift or rotate count comes from bits 16-20.
// - Bits 16-31 give a sign-extended 16-bit immediate.
// - Bits 16-31 give a zero-extended 16-bit immediate.
// - Special register selector is the 10-bit field at bits 11-20.
// - Trap condition mask comes from bits 6-10.
// - Bits 11-15 select a register used as source or destination.
// - Bit 21 enables overflow and summary overflow update; clear leaves them.
`timescale 1ns/1ns
module instruction_field_decoder (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_int_wb,
  input  wire logic [31:0] i_int_result,
  input  wire logic        i_int_overflow,
  input  wire logic        i_fp_wb,
  input  wire logic [3:0]  i_fp_exc,
  output logic             o_decode_valid,
  output logic [4:0]       o_store_src_field,
  output logic [4:0]       o_dest_field,
  output logic [4:0]       o_first_operand_field,
  output logic [4:0]       o_second_src_field,
  output logic [4:0]       o_rotate_count_field,
  output logic [31:0]      o_signed_imm_field,
  output logic [15:0]      o_unsigned_imm_field,
  output logic [9:0]       o_special_reg_select,
  output logic [4:0]       o_trap_cond_mask_field,
  output logic             o_record_flag,
  output logic             o_overflow_enable,
  output logic [0:7]       o_cond_flags_reg,
  output logic             o_signed_range_flag,
  output logic             o_summary_overflow
);
  logic [4:0]  store_sel_q;
  logic [15:0] imm_q;
  logic        record_q;
  logic        oe_q;
  logic        valid_q;
  logic [0:7]  cond_q;
  logic        range_flag_q;
  logic        so_q;
  logic        so_d;
  logic        int_neg;
  logic        int_zero;

  // Package field limits must agree with the fixed port widths
  generate
    if (decoder_pkg::IMM_LAST - decoder_pkg::IMM_FIRST + 1 != 16 ||
        decoder_pkg::SPECIAL_LAST - decoder_pkg::SPECIAL_FIRST + 1 != 10 ||
        decoder_pkg::STORE_SRC_LAST - decoder_pkg::STORE_SRC_FIRST + 1 != 5 ||
        decoder_pkg::FIRST_OP_LAST - decoder_pkg::FIRST_OP_FIRST + 1 != 5 ||
        decoder_pkg::SECOND_SRC_LAST - decoder_pkg::SECOND_SRC_FIRST + 1 != 5 ||
        decoder_pkg::ROTATE_LAST - decoder_pkg::ROTATE_FIRST + 1 != 5 ||
        decoder_pkg::TRAP_LAST - decoder_pkg::TRAP_FIRST + 1 != 5) begin : g_bad_fields
      $error("instruction_field_decoder: field widths disagree with ports");
    end
    if (decoder_pkg::RECORD_BIT > decoder_pkg::INSTR_W - 1 ||
        decoder_pkg::OVF_ENABLE_BIT > decoder_pkg::INSTR_W - 1) begin : g_bad_bits
      $error("instruction_field_decoder: control bit outside the word");
    end
  endgenerate

  field_slice #(
    .FIRST (decoder_pkg::STORE_SRC_FIRST),
    .LAST  (decoder_pkg::STORE_SRC_LAST)
  ) u_store_src (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (store_sel_q)
  );

  field_slice #(
    .FIRST (decoder_pkg::FIRST_OP_FIRST),
    .LAST  (decoder_pkg::FIRST_OP_LAST)
  ) u_first_op (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (o_first_operand_field)
  );

  field_slice #(
    .FIRST (decoder_pkg::SECOND_SRC_FIRST),
    .LAST  (decoder_pkg::SECOND_SRC_LAST)
  ) u_second_src (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (o_second_src_field)
  );

  // Same bits as the second source, kept apart so the shifter has its own copy
  field_slice #(
    .FIRST (decoder_pkg::ROTATE_FIRST),
    .LAST  (decoder_pkg::ROTATE_LAST)
  ) u_rotate (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (o_rotate_count_field)
  );

  field_slice #(
    .FIRST (decoder_pkg::IMM_FIRST),
    .LAST  (decoder_pkg::IMM_LAST)
  ) u_imm (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (imm_q)
  );

  field_slice #(
    .FIRST (decoder_pkg::SPECIAL_FIRST),
    .LAST  (decoder_pkg::SPECIAL_LAST)
  ) u_special (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (o_special_reg_select)
  );

  field_slice #(
    .FIRST (decoder_pkg::TRAP_FIRST),
    .LAST  (decoder_pkg::TRAP_LAST)
  ) u_trap (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_load  (i_instr_valid),
    .i_word  (i_instr),
    .o_field (o_trap_cond_mask_field)
  );

  // Single control bits of the word
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      record_q <= 1'b0;
      oe_q     <= 1'b0;
    end else if (i_instr_valid) begin
      record_q <= i_instr[31-decoder_pkg::RECORD_BIT];
      oe_q     <= i_instr[31-decoder_pkg::OVF_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= i_instr_valid;
    end
  end

  // Overflow flags of the exception register; summary overflow is sticky
  // Only reset clears it, so software sees any overflow with bit 21 set since the last reset
  assign so_d = so_q | (oe_q & i_int_wb & i_int_overflow);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      range_flag_q <= decoder_pkg::EXC_FLAG_RST;
      so_q         <= decoder_pkg::EXC_FLAG_RST;
    end else if (i_int_wb && oe_q) begin
      range_flag_q <= i_int_overflow;
      so_q         <= so_d;
    end
  end

  // Signed reading of the result; unsigned order is left to the zero flag
  assign int_neg  = i_int_result[31];
  assign int_zero = (i_int_result == 32'h0000_0000);

  // Condition flags; integer and float writebacks touch disjoint halves
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cond_q <= decoder_pkg::COND_FLAGS_RST;
    end else begin
      if (i_int_wb && record_q) begin
        cond_q[decoder_pkg::CF_LT]   <= int_neg;
        cond_q[decoder_pkg::CF_GT]   <= ~int_neg & ~int_zero;
        cond_q[decoder_pkg::CF_ZERO] <= int_zero;
        cond_q[decoder_pkg::CF_SO]   <= so_d;
      end
      if (i_fp_wb && record_q) begin
        cond_q[decoder_pkg::CF_FX]  <= i_fp_exc[3];
        cond_q[decoder_pkg::CF_FEX] <= i_fp_exc[2];
        cond_q[decoder_pkg::CF_VX]  <= i_fp_exc[1];
        cond_q[decoder_pkg::CF_OX]  <= i_fp_exc[0];
      end
    end
  end

  assign o_decode_valid       = valid_q;
  assign o_store_src_field    = store_sel_q;
  assign o_dest_field         = store_sel_q;
  assign o_signed_imm_field   = {{16{imm_q[15]}}, imm_q};
  assign o_unsigned_imm_field = imm_q;
  assign o_record_flag        = record_q;
  assign o_overflow_enable    = oe_q;
  assign o_cond_flags_reg     = cond_q;
  assign o_signed_range_flag  = range_flag_q;
  assign o_summary_overflow   = so_q;
endmodule

// >>> verification/instruction_field_decoder_asserts.sv
// Port assertions for the instruction field decoder.
`timescale 1ns/1ns
module instruction_field_decoder_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic        i_int_wb,
  input wire logic [31:0] i_int_result,
  input wire logic        i_fp_wb,
  input wire logic [3:0]  i_fp_exc,
  input wire logic [4:0]  o_store_src_field,
  input wire logic [4:0]  o_dest_field,
  input wire logic [4:0]  o_first_operand_field,
  input wire logic [4:0]  o_second_src_field,
  input wire logic [4:0]  o_rotate_count_field,
  input wire logic [31:0] o_signed_imm_field,
  input wire logic [15:0] o_unsigned_imm_field,
  input wire logic [9:0]  o_special_reg_select,
  input wire logic [4:0]  o_trap_cond_mask_field,
  input wire logic        o_record_flag,
  input wire logic        o_overflow_enable,
  input wire logic [0:7]  o_cond_flags_reg,
  input wire logic        o_signed_range_flag
);
  logic [2:0] int_exp;
  // Sign, positive, zero of the result seen as signed
  assign int_exp = {i_int_result[31], !i_int_result[31] && |i_int_result, ~|i_int_result};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  src_sel_a: assert property (i_instr_valid |=> o_store_src_field == $past(i_instr[25:21]) &&
    o_dest_field == $past(i_instr[25:21]) && o_second_src_field == $past(i_instr[15:11])) else $error("bad sel");
  record_keep_a: assert property (!(o_record_flag && (i_int_wb || i_fp_wb)) |=>
    $stable(o_cond_flags_reg)) else $error("flags moved");
  int_flags_a: assert property (i_int_wb && o_record_flag |=>
    o_cond_flags_reg[0:2] == $past(int_exp)) else $error("bad int flags");
  fp_flags_a: assert property (i_fp_wb && o_record_flag |=>
    o_cond_flags_reg[4:7] == $past(i_fp_exc)) else $error("bad fp flags");
  shift_amt_a: assert property (i_instr_valid |=>
    o_rotate_count_field == $past(i_instr[15:11])) else $error("bad shift");
  imm_fields_a: assert property (i_instr_valid |=> o_unsigned_imm_field == $past(i_instr[15:0]) &&
    o_signed_imm_field == {{16{$past(i_instr[15])}}, $past(i_instr[15:0])}) else $error("bad imm");
  special_trap_a: assert property (i_instr_valid |=> o_special_reg_select == $past(i_instr[20:11]) &&
    o_trap_cond_mask_field == $past(i_instr[25:21])) else $error("bad spr");
  first_op_a: assert property (i_instr_valid |=>
    o_first_operand_field == $past(i_instr[20:16])) else $error("bad first");
  range_keep_a: assert property (!(o_overflow_enable && i_int_wb) |=>
    $stable(o_signed_range_flag)) else $error("ov moved");
  bit_order_a: assert property (i_instr_valid |=> o_record_flag == $past(i_instr[0]) &&
    o_overflow_enable == $past(i_instr[10])) else $error("bad order");
  cover property (i_int_wb && o_record_flag && o_overflow_enable);
  cover property (i_fp_wb && i_int_wb && o_record_flag);
  cover property (i_instr_valid ##1 i_instr_valid);
endmodule

// >>> verification/fetch_model.sv
// Fetch stage stand-in presenting one word per requested cycle.
`timescale 1ns/1ns
module fetch_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [31:0] i_word,
  output logic             o_valid,
  output logic [31:0]      o_instr
);
  // Idle bus inverts its previous value each cycle instead of holding the last word
  always_ff @(posedge i_clk) begin
    o_valid <= i_go;
    o_instr <= i_go ? i_word : ~o_instr;
  end
endmodule

// >>> verification/instruction_field_decoder_test.sv
// Self-checking bench for the instruction field decoder.
`timescale 1ns/1ns
module instruction_field_decoder_test;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        go = 1'b0;
  logic [31:0] word = 32'h0;
  logic        int_wb = 1'b0;
  logic [31:0] res = 32'h0;
  logic        ovf = 1'b0;
  logic        fp_wb = 1'b0;
  logic [3:0]  exc = 4'h0;
  logic        vld, dv, rec, oe, rng, so;
  logic [31:0] ins, si;
  logic [4:0]  ss, ds, fo, s2, rot, tm;
  logic [15:0] ui;
  logic [9:0]  sp;
  logic [0:7]  cf;
  int          cmp_count = 0;
  int          n_mismatch = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  fetch_model fetch_model_i (.i_clk(clk), .i_go(go), .i_word(word), .o_valid(vld), .o_instr(ins));
  instruction_field_decoder instruction_field_decoder_i (.i_clk(clk), .i_rst_b(rst_b), .i_instr_valid(vld),
    .i_instr(ins), .i_int_wb(int_wb), .i_int_result(res), .i_int_overflow(ovf), .i_fp_wb(fp_wb),
    .i_fp_exc(exc), .o_decode_valid(dv), .o_store_src_field(ss), .o_dest_field(ds),
    .o_first_operand_field(fo), .o_second_src_field(s2), .o_rotate_count_field(rot),
    .o_signed_imm_field(si), .o_unsigned_imm_field(ui), .o_special_reg_select(sp),
    .o_trap_cond_mask_field(tm), .o_record_flag(rec), .o_overflow_enable(oe), .o_cond_flags_reg(cf),
    .o_signed_range_flag(rng), .o_summary_overflow(so));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic fields(input logic [31:0] w);
    chk({ss, ds, tm}, {3{w[25:21]}});
    chk({s2, rot, fo}, {w[15:11], w[15:11], w[20:16]});
    chk(si, {{16{w[15]}}, w[15:0]});
    chk({ui, sp}, {w[15:0], w[20:11]});
    chk({rec, oe, dv}, {w[0], w[10], 1'b1});
  endtask
  task automatic dec(input logic [31:0] w);
    tick;
    go = 1'b1;
    word = w;
    tick;
    go = 1'b0;
    tick;
  endtask
  task automatic wb(input logic i, input logic [31:0] r, input logic o, input logic f, input logic [3:0] e);
    tick;
    int_wb = i;
    res = r;
    ovf = o;
    fp_wb = f;
    exc = e;
    tick;
    int_wb = 1'b0;
    fp_wb = 1'b0;
  endtask
  // Two words back to back, first with a negative immediate
  task automatic t_fields;
    tick;
    go = 1'b1;
    word = 32'h7E4B_9A01;
    tick;
    word = 32'h8123_4702;
    tick;
    go = 1'b0;
    fields(32'h7E4B_9A01);
    tick;
    fields(32'h8123_4702);
    $display("fields test done");
  endtask
  task automatic t_int;
    dec(32'h0000_0401);
    wb(1'b1, 32'h8000_0000, 1'b1, 1'b0, 4'h0);
    chk({cf, rng, so}, {8'h90, 2'h3});
    wb(1'b1, 32'h0000_0005, 1'b0, 1'b0, 4'h0);
    chk({cf, rng, so}, {8'h50, 2'h1});
    wb(1'b1, 32'h0000_0000, 1'b0, 1'b0, 4'h0);
    chk({cf, rng, so}, {8'h30, 2'h1});
    $display("integer flags test done");
  endtask
  task automatic t_keep;
    dec(32'h0000_0000);
    wb(1'b1, 32'h8000_0000, 1'b1, 1'b1, 4'hF);
    chk({cf, rng, so}, {8'h30, 2'h1});
    $display("no record test done");
  endtask
  // Both halves written at the same edge, overflow update off
  task automatic t_fp;
    dec(32'h0000_0001);
    wb(1'b1, 32'h8000_0000, 1'b1, 1'b1, 4'hA);
    chk({cf, rng, so}, {8'h9A, 2'h1});
    $display("float flags test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 200) begin
      n_mismatch++;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    t_fields;
    t_int;
    t_keep;
    t_fp;
    results;
  end
endmodule
bind instruction_field_decoder instruction_field_decoder_asserts instruction_field_decoder_asserts_i (.i_clk,
  .i_rst_b, .i_instr_valid, .i_instr, .i_int_wb, .i_int_result, .i_fp_wb, .i_fp_exc, .o_store_src_field,
  .o_dest_field, .o_first_operand_field, .o_second_src_field, .o_rotate_count_field, .o_signed_imm_field,
  .o_unsigned_imm_field, .o_special_reg_select, .o_trap_cond_mask_field, .o_record_flag, .o_overflow_enable,
  .o_cond_flags_reg, .o_signed_range_flag);
